// ===== rtl/obcd_decoder.sv
// Option byte fetch, decode and AHB-Lite readback of the settings.
//
// How it works
// - Fetch all option bytes after each reset, apply before normal operation.
// - Watchdog runs after reset when run-enable bit is one.
// - Two-bit level field picks one of four power-on-reset thresholds.
// - Reset-pin bit zero gives port/key pin, one gives reset input.
// - Oscillator codes 1 to 5 give 20 down to 1.25 MHz.
// - Top bit of debug option byte enables on-chip debug.
// - Failed security ID check never erases flash contents.
// - Debug byte bits three and one are unstable and never used.
`timescale 1ns/10ps
`include "obcd_map.svh"
module obcd_decoder (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flash option byte read port.
  output logic flash_rd_req,
  output logic [9:0] flash_rd_addr,
  input wire logic flash_rd_ack,
  input wire logic [7:0] flash_rd_data,
  // Decoded configuration.
  output obcd_pkg::obcd_cfg_t cfg,
  output logic flash_erase_on_auth_fail
);
  import obcd_pkg::*;

  obcd_state_t state_q, state_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] opt_q [4];
  logic [7:0] opt_d [4];
  logic req_q, req_d;
  logic [9:0] addr_q, addr_d;
  obcd_cfg_t cfg_q, cfg_d;
  logic [9:0] addr_tab [4];

  assign addr_tab[0] = `OBCD_ADDR_WDT_OPT;
  assign addr_tab[1] = `OBCD_ADDR_POR_OPT;
  assign addr_tab[2] = `OBCD_ADDR_OSC_OPT;
  assign addr_tab[3] = `OBCD_ADDR_DBG_OPT;

  // The flash is read once per reset; afterwards the fetch sits in DONE.
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    req_d = req_q;
    addr_d = addr_q;
    for (int i = 0; i < 4; i++) begin
      opt_d[i] = opt_q[i];
    end
    unique case (state_q)
      OBCD_IDLE: begin
        state_d = OBCD_REQ;
        idx_d = 2'h0;
      end
      OBCD_REQ: begin
        req_d = 1'b1;
        addr_d = addr_tab[idx_q];
        state_d = OBCD_WAIT;
      end
      OBCD_WAIT: begin
        if (flash_rd_ack) begin
          req_d = 1'b0;
          opt_d[idx_q] = flash_rd_data;
          if (idx_q == `OBCD_BYTES) begin
            state_d = OBCD_DONE;
          end else begin
            idx_d = idx_q + 2'h1;
            state_d = OBCD_REQ;
          end
        end
      end
      OBCD_DONE: begin
        state_d = OBCD_DONE;
      end
    endcase
  end

  // Decoded fields are loaded only on the transition into DONE.
  always_comb begin
    cfg_d = cfg_q;
    if (state_q == OBCD_WAIT && state_d == OBCD_DONE) begin
      cfg_d.wdt_run_enable = opt_d[0][`OBCD_WDT_RUN_BIT];
      cfg_d.wdt_standby_run = opt_d[0][`OBCD_WDT_STBY_BIT] &
        opt_d[0][`OBCD_WDT_RUN_BIT];
      cfg_d.wdt_period_sel = opt_d[0][`OBCD_WDT_PER_LSB +: 3];
      cfg_d.reset_pin_select = opt_d[1][`OBCD_RST_PIN_BIT];
      cfg_d.por_level_sel = opt_d[1][`OBCD_POR_LSB +: 2];
      cfg_d.osc_freq_sel = opt_d[2][`OBCD_OSC_LSB +: 3];
      cfg_d.osc_cfg_error = (opt_d[2][`OBCD_OSC_LSB +: 3] < `OBCD_OSC_MIN) |
        (opt_d[2][`OBCD_OSC_LSB +: 3] > `OBCD_OSC_MAX);
      cfg_d.debug_enable_bit = opt_d[3][`OBCD_DBG_BIT];
      cfg_d.cfg_valid = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= OBCD_IDLE;
      idx_q <= 2'h0;
      req_q <= 1'b0;
      addr_q <= 10'h000;
      cfg_q <= '0;
      for (int i = 0; i < 4; i++) begin
        opt_q[i] <= `OBCD_RST_OPT;
      end
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      req_q <= req_d;
      addr_q <= addr_d;
      cfg_q <= cfg_d;
      for (int i = 0; i < 4; i++) begin
        opt_q[i] <= opt_d[i];
      end
    end
  end

  assign flash_rd_req = req_q;
  assign flash_rd_addr = addr_q;
  assign cfg = cfg_q;

  // AHB-Lite slave: zero wait states, read-only, always OKAY.
  logic rd_take;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic resp_q, resp_d;
  logic erase_q, erase_d;
  logic [7:0] dbg_view;

  // Bits three and one of the debug byte are masked from all use.
  assign dbg_view = opt_q[3] & 8'hf5;

  // The word is looked up in the address phase and registered, so it
  // stands for the whole data phase straight from a flip-flop.
  always_comb begin
    rd_take = hsel & hready & htrans[1] & ~hwrite;
    rdata_d = 32'h0000_0000;
    ready_d = 1'b1;
    resp_d = 1'b0;
    // Security ID failure never erases flash contents.
    erase_d = 1'b0;
    if (rd_take) begin
      unique case (haddr[11:0] & 12'hffc)
        `OBCD_OFS_WDT: rdata_d = {24'h00_0000, opt_q[0]};
        `OBCD_OFS_POR: rdata_d = {24'h00_0000, opt_q[1]};
        `OBCD_OFS_OSC_WORD: rdata_d = {24'h00_0000, opt_q[2]};
        `OBCD_OFS_DBG_WORD: rdata_d = {24'h00_0000, dbg_view};
        `OBCD_OFS_STATUS: rdata_d = {18'h0, cfg_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b1;
      resp_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      resp_q <= resp_d;
      erase_q <= erase_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = ready_q;
  assign hresp = resp_q;
  assign flash_erase_on_auth_fail = erase_q;

  logic unused_ok;
  assign unused_ok = ^{hwdata, hsize, htrans[0], haddr[31:12], haddr[1:0]};

  property p_cfg_hold;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == OBCD_DONE) |=> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed");

  property p_wdt_run;
    @(posedge hclk) disable iff (!hresetn)
    $rose(cfg_q.cfg_valid) |-> cfg_q.wdt_run_enable == opt_q[0][4];
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("wdt run");

  property p_osc_err;
    @(posedge hclk) disable iff (!hresetn)
    cfg_q.cfg_valid |-> cfg_q.osc_cfg_error ==
      (opt_q[2][2:0] == 3'h0 || opt_q[2][2:0] > 3'h5);
  endproperty
  a_osc_err: assert property (p_osc_err) else $error("osc error");

  property p_rst_pin;
    @(posedge hclk) disable iff (!hresetn)
    cfg_q.cfg_valid |-> cfg_q.reset_pin_select == opt_q[1][4];
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin");

  property p_por;
    @(posedge hclk) disable iff (!hresetn)
    cfg_q.cfg_valid |-> cfg_q.por_level_sel == opt_q[1][3:2];
  endproperty
  a_por: assert property (p_por) else $error("por level");

  property p_osc_sel;
    @(posedge hclk) disable iff (!hresetn)
    cfg_q.cfg_valid |-> cfg_q.osc_freq_sel == opt_q[2][2:0];
  endproperty
  a_osc_sel: assert property (p_osc_sel) else $error("osc sel");

  property p_dbg;
    @(posedge hclk) disable iff (!hresetn)
    cfg_q.cfg_valid |-> cfg_q.debug_enable_bit == opt_q[3][7];
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug enable");

  property p_fetch;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == OBCD_WAIT && flash_rd_ack && idx_q == 2'h3) |=>
      cfg_q.cfg_valid;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch end");

  property p_no_erase;
    @(posedge hclk) disable iff (!hresetn)
    !flash_erase_on_auth_fail;
  endproperty
  a_no_erase: assert property (p_no_erase) else $error("erase");

  property p_mask;
    @(posedge hclk) disable iff (!hresetn)
    dbg_view[3] == 1'b0 && dbg_view[1] == 1'b0;
  endproperty
  a_mask: assert property (p_mask) else $error("unstable bits");
endmodule

// ===== rtl/obcd_map.svh
// Register offsets, option byte layouts and load constants of the decoder.
`ifndef OBCD_MAP_SVH
`define OBCD_MAP_SVH
`define OBCD_ADDR_WDT_OPT 10'h0c0
`define OBCD_ADDR_POR_OPT 10'h0c1
`define OBCD_ADDR_OSC_OPT 10'h0c2
`define OBCD_ADDR_DBG_OPT 10'h0c3
// Each option register's byte address is four times its option byte flash address.
`define OBCD_OFS_WDT {`OBCD_ADDR_WDT_OPT, 2'b00}
`define OBCD_OFS_POR {`OBCD_ADDR_POR_OPT, 2'b00}
`define OBCD_OFS_STATUS 12'h100
`define OBCD_OFS_OSC_WORD {`OBCD_ADDR_OSC_OPT, 2'b00}
`define OBCD_OFS_DBG_WORD {`OBCD_ADDR_DBG_OPT, 2'b00}
`define OBCD_WDT_RUN_BIT 4
`define OBCD_WDT_PER_LSB 1
`define OBCD_WDT_STBY_BIT 0
`define OBCD_RST_PIN_BIT 4
`define OBCD_POR_LSB 2
`define OBCD_OSC_LSB 0
`define OBCD_DBG_BIT 7
`define OBCD_OSC_MIN 3'h1
`define OBCD_OSC_MAX 3'h5
`define OBCD_BYTES 2'h3
`define OBCD_RST_OPT 8'h00
`endif

// ===== rtl/obcd_pkg.sv
// Types shared by the option byte decoder.
package obcd_pkg;
  typedef enum logic [1:0] {
    OBCD_IDLE = 2'b00,
    OBCD_REQ = 2'b01,
    OBCD_WAIT = 2'b10,
    OBCD_DONE = 2'b11
  } obcd_state_t;

  typedef struct packed {
    logic wdt_run_enable;
    logic wdt_standby_run;
    logic [2:0] wdt_period_sel;
    logic reset_pin_select;
    logic [1:0] por_level_sel;
    logic [2:0] osc_freq_sel;
    logic osc_cfg_error;
    logic debug_enable_bit;
    logic cfg_valid;
  } obcd_cfg_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } obcd_ahb_rsp_t;
endpackage

// ===== tb/obcd_flash_model.sv
// Behavioural option byte area of the flash answering byte reads.
`timescale 1ns/10ps
module obcd_flash_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Byte read port.
  input wire logic flash_rd_req,
  input wire logic [9:0] flash_rd_addr,
  output logic flash_rd_ack,
  output logic [7:0] flash_rd_data
);
  logic [7:0] mem [4];
  logic [7:0] last_q = 8'h00;
  logic order_bad = 1'b0;
  int dly = 0;
  int cnt = 0;
  int n_ack = 0;
  // Outside the answer the data lines show a changed value, not the last.
  assign flash_rd_data = flash_rd_ack ? last_q : ~last_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_rd_ack <= 1'b0;
      cnt <= 0;
      n_ack <= 0;
    end else begin
      flash_rd_ack <= 1'b0;
      if (flash_rd_req && !flash_rd_ack) begin
        if (cnt >= dly) begin
          flash_rd_ack <= 1'b1;
          last_q <= mem[flash_rd_addr[1:0]];
          cnt <= 0;
          n_ack <= n_ack + 1;
          if (flash_rd_addr !== 10'h0c0 + 10'(n_ack)) begin
            order_bad <= 1'b1;
          end
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench of the option byte decoder.
`timescale 1ns/10ps
module tb_top;
  import obcd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, req, ack, erase;
  logic [9:0] addr;
  logic [7:0] data;
  obcd_cfg_t cfg;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 hclk = ~hclk;
  obcd_decoder uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_rd_req(req),
    .flash_rd_addr(addr), .flash_rd_ack(ack), .flash_rd_data(data),
    .cfg(cfg), .flash_erase_on_auth_fail(erase));
  obcd_flash_model fm (.hclk(hclk), .hresetn(hresetn), .flash_rd_req(req),
    .flash_rd_addr(addr), .flash_rd_ack(ack), .flash_rd_data(data));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [13:0] ecfg(logic [7:0] w, p, o, d);
    logic err;
    err = (o[2:0] < 3'h1) || (o[2:0] > 3'h5);
    return {w[4], w[4] & w[0], w[3:1], p[4], p[3:2], o[2:0], err, d[7],
      1'b1};
  endfunction
  task automatic ahb(logic wr, logic [31:0] a, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= 32'h0000_0000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, v);
    chk("hrdata", e, v);
  endtask
  task automatic load(logic [7:0] w, p, o, d, int dl);
    logic [13:0] e;
    fm.mem = '{w, p, o, d};
    fm.dly = dl;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 200 && cfg.cfg_valid !== 1'b1; i++) @(posedge hclk);
    e = ecfg(w, p, o, d);
    chk("fetch count", 32'd4, fm.n_ack);
    chk("fetch order", 32'd0, {31'd0, fm.order_bad});
    chk("cfg", {18'h0, e}, {18'h0, cfg});
  endtask
  task automatic t_regs();
    logic [31:0] v;
    rd(32'h300, 32'hf7);
    rd(32'h304, 32'he7);
    rd(32'h308, 32'hfd);
    rd(32'h30c, 32'h85 & 32'hf5);
    rd(32'h100, {18'h0, ecfg(8'hf7, 8'he7, 8'hfd, 8'h85)});
    rd(32'h0f0, 32'h0);
    ahb(1'b1, 32'h300, v);
    rd(32'h300, 32'hf7);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("erase", 32'h0, {31'h0, erase});
  endtask
  task automatic t_hold();
    logic [13:0] e;
    e = cfg;
    fm.mem = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge hclk);
    chk("cfg hold", e, cfg);
    rd(32'h308, 32'hfd);
  endtask
  task automatic t_codes();
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      load({3'h7, c[0], c, c[0]}, {3'h7, c[1], c[1:0], 2'h3}, {5'h1f, c},
        {c[0], 7'h05}, k);
    end
  endtask
  task automatic t_bad();
    load(8'he1, 8'hf3, 8'hfd, 8'h0f, 2);
    rd(32'h30c, 32'h05);
    rd(32'h100, {18'h0, ecfg(8'he1, 8'hf3, 8'hfd, 8'h0f)});
  endtask
  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    load(8'hf7, 8'he7, 8'hfd, 8'h85, 0);
    t_regs();
    t_hold();
    t_codes();
    t_bad();
    summarize();
  end
endmodule
